// ### logic/alu_branch_execute.sv
// Execute stage of a small 8-bit core: arithmetic, flags, skips, branches, jumps.
// Assumes the decoder holds operands steady with op_valid_in and honours busy_out.
module alu_branch_execute
  import exec_pkg::*;
(
  input wire logic mclk_in, // Core clock, 20 MHz
  input wire logic reset_in, // Synchronous reset, active high
  input wire logic op_valid_in, // Operation offered this cycle
  input wire op_type op_code_in, // Operation to execute
  input wire logic [7:0] rd_in, // Destination register value
  input wire logic [7:0] rr_in, // Source register value
  input wire logic [7:0] imm_in, // Immediate constant or mask
  input wire logic use_imm_in, // Take immediate instead of source register
  input wire logic [7:0] io_byte_in, // I/O register value for bit skips
  input wire logic [2:0] bit_sel_in, // Bit or status flag index
  input wire logic [11:0] offset_in, // Signed relative offset, sign extended
  input wire logic [21:0] pc_in, // Address of the current instruction
  input wire logic [15:0] z_in, // Z pointer value
  input wire logic [21:0] stack_pc_in, // Return address popped from the stack
  input wire logic next_two_word_in, // Following instruction is two words long
  input wire logic status_write_in, // Load status directly
  input wire logic [7:0] status_wdata_in, // Status value to load
  output logic [7:0] result_out, // Value to write back
  output logic result_we_out, // Write result to destination
  output logic [7:0] status_out, // Status flags
  output logic [21:0] pc_out, // Next program counter
  output logic done_out, // Operation finished, pulse
  output logic busy_out, // Operation still running
  output logic [2:0] cycles_out, // Cycles the last operation took
  output logic push_out, // Push return address, pulse
  output logic [21:0] push_addr_out, // Return address to push
  output logic illegal_out // Unimplemented operation refused, pulse
);
  `include "exec_map.svh"

  alu_link_if lk ();

  state_type state_reg;
  logic [2:0] remain_reg;
  logic [7:0] status_reg;
  logic [7:0] result_reg;
  logic result_we_reg;
  logic [21:0] pc_reg;
  logic [21:0] pend_pc_reg;
  logic pend_push_reg;
  logic pend_interrupt_return_reg;
  logic done_reg;
  logic busy_reg;
  logic [2:0] cycles_reg;
  logic push_reg;
  logic [21:0] push_addr_reg;
  logic illegal_reg;
  logic go;
  logic [2:0] cyc_next;
  logic [21:0] pc_next;
  logic [21:0] pc_plus1;
  logic [21:0] pc_target;
  logic push_next;
  logic illegal_next;
  logic [1:0] cond;

  // Branch and skip decision: bit 1 marks a conditional, bit 0 the outcome
  function automatic logic [1:0] branch_cond(input op_type op, input logic [7:0] st,
    input logic [2:0] sel, input logic [7:0] rr, input logic [7:0] io,
    input logic [7:0] rd);
    logic [1:0] res;
    res = 2'b10;
    case (op)
      OP_COMPARE_SKIP_EQUAL: res[0] = (rd == rr);
      OP_SKIP_REG_BIT_CLEAR: res[0] = ~rr[sel];
      OP_SKIP_REG_BIT_SET: res[0] = rr[sel];
      OP_SKIP_IO_BIT_CLEAR: res[0] = ~io[sel];
      OP_SKIP_IO_BIT_SET: res[0] = io[sel];
      OP_BRANCH_FLAG_SET: res[0] = st[sel];
      OP_BRANCH_FLAG_CLEAR: res[0] = ~st[sel];
      OP_BRANCH_EQUAL: res[0] = st[`FLAG_Z];
      OP_BRANCH_NOT_EQUAL: res[0] = ~st[`FLAG_Z];
      OP_BRANCH_MINUS: res[0] = st[`FLAG_N];
      OP_BRANCH_PLUS: res[0] = ~st[`FLAG_N];
      OP_BRANCH_SIGNED_GE: res[0] = ~(st[`FLAG_N] ^ st[`FLAG_V]);
      OP_BRANCH_SIGNED_LT: res[0] = st[`FLAG_N] ^ st[`FLAG_V];
      OP_BRANCH_UNSIGNED_GE: res[0] = ~st[`FLAG_C];
      OP_BRANCH_UNSIGNED_LT: res[0] = st[`FLAG_C];
      OP_BRANCH_CARRY_CLEAR: res[0] = ~st[`FLAG_C];
      OP_BRANCH_CARRY_SET: res[0] = st[`FLAG_C];
      OP_BRANCH_HALFCARRY_SET: res[0] = st[`FLAG_H];
      OP_BRANCH_HALFCARRY_CLEAR: res[0] = ~st[`FLAG_H];
      OP_BRANCH_TRANSFER_SET: res[0] = st[`FLAG_T];
      OP_BRANCH_TRANSFER_CLEAR: res[0] = ~st[`FLAG_T];
      OP_BRANCH_OVERFLOW_SET: res[0] = st[`FLAG_V];
      OP_BRANCH_OVERFLOW_CLEAR: res[0] = ~st[`FLAG_V];
      OP_BRANCH_IRQ_ENABLED: res[0] = st[`FLAG_I];
      OP_BRANCH_IRQ_DISABLED: res[0] = ~st[`FLAG_I];
      default: res = 2'b00;
    endcase
    return res;
  endfunction

  // Operands to the arithmetic core
  always_comb
  begin
    lk.op = op_code_in;
    lk.rd = rd_in;
    lk.operand = use_imm_in ? imm_in : rr_in;
    lk.status_old = status_reg;
  end

  alu_core u_alu (
    .lk(lk)
  );

  assign go = op_valid_in && (state_reg == ST_IDLE);
  assign pc_plus1 = 22'(pc_in + 22'h000001);
  assign pc_target = 22'(pc_plus1 + {{10{offset_in[11]}}, offset_in});
  assign cond = branch_cond(op_code_in, status_reg, bit_sel_in, rr_in, io_byte_in, rd_in);

  // Next address, cycle count and side effects of the offered operation
  always_comb
  begin
    cyc_next = `CYC_ONE;
    pc_next = pc_plus1;
    push_next = 1'b0;
    illegal_next = 1'b0;
    case (op_code_in)
      OP_WORD_ADD_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE: illegal_next = 1'b1;
      OP_RELATIVE_JUMP:
      begin
        cyc_next = `CYC_TWO;
        pc_next = pc_target;
      end
      OP_RELATIVE_CALL:
      begin
        cyc_next = `CYC_THREE;
        pc_next = pc_target;
        push_next = 1'b1;
      end
      OP_INDIRECT_JUMP:
      begin
        cyc_next = `CYC_TWO;
        pc_next = {`PC_UPPER_ZERO, z_in};
      end
      OP_INDIRECT_CALL:
      begin
        cyc_next = `CYC_THREE;
        pc_next = {`PC_UPPER_ZERO, z_in};
        push_next = 1'b1;
      end
      OP_RETURN, OP_INTERRUPT_RETURN:
      begin
        cyc_next = `CYC_RETURN;
        pc_next = stack_pc_in;
      end
      OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
      OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET:
      begin
        if (cond[0])
        begin
          // Skipping a two-word instruction lands one word further on
          cyc_next = `CYC_TWO;
          pc_next = 22'(pc_in + (next_two_word_in ? 22'h000003 : 22'h000002));
        end
      end
      default:
      begin
        if (cond[1] && cond[0])
        begin
          cyc_next = `CYC_TWO;
          pc_next = pc_target;
        end
      end
    endcase
  end

  // Controller: one-cycle operations finish at once, others count down
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      state_reg <= ST_IDLE;
      remain_reg <= 3'h0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (go && (cyc_next != `CYC_ONE))
          begin
            state_reg <= ST_WAIT;
            remain_reg <= 3'(cyc_next - 3'h1);
          end
        end
        ST_WAIT:
        begin
          remain_reg <= 3'(remain_reg - 3'h1);
          if (remain_reg == 3'h1)
          begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Held transfer results for multi-cycle operations
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      pend_pc_reg <= `PC_RESET;
      pend_push_reg <= 1'b0;
      pend_interrupt_return_reg <= 1'b0;
    end
    else if (go)
    begin
      pend_pc_reg <= pc_next;
      pend_push_reg <= push_next;
      pend_interrupt_return_reg <= (op_code_in == OP_INTERRUPT_RETURN);
    end
  end

  // Status flags; a finishing interrupt return wins over a direct load
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      status_reg <= `STATUS_RESET;
    end
    else if (state_reg == ST_WAIT && remain_reg == 3'h1 && pend_interrupt_return_reg)
    begin
      status_reg[`FLAG_I] <= 1'b1;
    end
    else if (go && lk.flag_write)
    begin
      status_reg <= lk.status_new;
    end
    else if (status_write_in)
    begin
      status_reg <= status_wdata_in;
    end
  end

  // Registered outputs: pulses last exactly the finishing cycle
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      result_reg <= 8'h00;
      result_we_reg <= 1'b0;
      pc_reg <= `PC_RESET;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
      cycles_reg <= 3'h0;
      push_reg <= 1'b0;
      push_addr_reg <= `PC_RESET;
      illegal_reg <= 1'b0;
    end
    else
    begin
      result_we_reg <= 1'b0;
      done_reg <= 1'b0;
      push_reg <= 1'b0;
      illegal_reg <= 1'b0;
      if (go)
      begin
        cycles_reg <= cyc_next;
        push_addr_reg <= pc_plus1;
        if (cyc_next == `CYC_ONE)
        begin
          done_reg <= 1'b1;
          pc_reg <= pc_next;
          result_reg <= lk.result;
          result_we_reg <= lk.write_en && !illegal_next;
          illegal_reg <= illegal_next;
        end
        else
        begin
          busy_reg <= 1'b1;
        end
      end
      else if (state_reg == ST_WAIT && remain_reg == 3'h1)
      begin
        busy_reg <= 1'b0;
        done_reg <= 1'b1;
        pc_reg <= pend_pc_reg;
        push_reg <= pend_push_reg;
      end
    end
  end

  assign result_out = result_reg;
  assign result_we_out = result_we_reg;
  assign status_out = status_reg;
  assign pc_out = pc_reg;
  assign done_out = done_reg;
  assign busy_out = busy_reg;
  assign cycles_out = cycles_reg;
  assign push_out = push_reg;
  assign push_addr_out = push_addr_reg;
  assign illegal_out = illegal_reg;

  // Expected branch target, captured for the checks below
  logic [21:0] exp_pc_reg;
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      exp_pc_reg <= `PC_RESET;
    end
    else if (go)
    begin
      exp_pc_reg <= 22'(pc_in + {{10{offset_in[11]}}, offset_in} + 22'h000001);
    end
  end

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_two_cycle;
    (busy_out && !done_out) ##1 (done_out && !busy_out);
  endsequence
  sequence s_three_cycle;
    busy_out[*2] ##1 (done_out && !busy_out);
  endsequence

  property p_sub_one_cycle;
    go && op_code_in == OP_SUBTRACT_IMMEDIATE |=> done_out && result_we_out && cycles_out == 3'h1;
  endproperty
  a_sub_one_cycle: assert property (p_sub_one_cycle) else $error("subtract not one cycle");

  property p_word_refused;
    go && op_code_in == OP_WORD_ADD_IMMEDIATE |=> illegal_out && !result_we_out;
  endproperty
  a_word_refused: assert property (p_word_refused) else $error("word op not refused");

  property p_and_keeps_carry;
    go && op_code_in == OP_AND_IMMEDIATE && !status_write_in
      |=> status_out[`FLAG_C] == $past(status_out[`FLAG_C])
      && status_out[`FLAG_H] == $past(status_out[`FLAG_H]) && !status_out[`FLAG_V];
  endproperty
  a_and_keeps_carry: assert property (p_and_keeps_carry) else $error("AND touched C/H");

  property p_test_no_write;
    go && op_code_in == OP_TEST_REGISTER |=> done_out && !result_we_out
      && status_out[`FLAG_Z] == ($past(rd_in) == 8'h00);
  endproperty
  a_test_no_write: assert property (p_test_no_write) else $error("test wrote register");

  property p_skip_taken;
    go && op_code_in == OP_COMPARE_SKIP_EQUAL && rd_in == rr_in && !next_two_word_in
      |=> s_two_cycle ##0 pc_out == 22'($past(pc_in, 2) + 22'h000002);
  endproperty
  a_skip_taken: assert property (p_skip_taken) else $error("skip not two cycles");

  property p_branch_taken;
    go && op_code_in == OP_BRANCH_FLAG_SET && status_out[bit_sel_in]
      |=> s_two_cycle ##0 pc_out == exp_pc_reg;
  endproperty
  a_branch_taken: assert property (p_branch_taken) else $error("bad taken branch");

  property p_unsigned_not_taken;
    go && op_code_in == OP_BRANCH_UNSIGNED_LT && !status_out[`FLAG_C]
      |=> done_out && !busy_out && pc_out == 22'($past(pc_in) + 22'h000001);
  endproperty
  a_unsigned_not_taken: assert property (p_unsigned_not_taken) else $error("bad not-taken");

  property p_indirect_jump;
    go && op_code_in == OP_INDIRECT_JUMP |=> s_two_cycle ##0 pc_out[21:16] == 6'h00;
  endproperty
  a_indirect_jump: assert property (p_indirect_jump) else $error("indirect jump wrong");

  property p_indirect_call;
    go && op_code_in == OP_INDIRECT_CALL |=> s_three_cycle ##0 push_out;
  endproperty
  a_indirect_call: assert property (p_indirect_call) else $error("indirect call wrong");

  property p_interrupt_return;
    go && op_code_in == OP_INTERRUPT_RETURN |=> busy_out[*5] ##1 (done_out && status_out[7]);
  endproperty
  a_interrupt_return: assert property (p_interrupt_return) else $error("interrupt return wrong");
endmodule

// ### logic/alu_core.sv
// Eight-bit arithmetic and logic core: result, write enable and merged status.
// Assumes the controller picks register or immediate operand before the link.
module alu_core
  import exec_pkg::*;
(
  alu_link_if.core lk // Operands in, result and flags out
);
  `include "exec_map.svh"
  logic [8:0] sum;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] r;
  logic ci;
  logic c;
  logic h;
  logic v;
  logic is_sub;
  logic is_arith;
  logic keep_z;
  logic upd_c;
  logic upd_h;
  logic z;

  // Operation select; adder shared by add, subtract, compare, increment and negate
  always_comb
  begin
    a = lk.rd;
    b = lk.operand;
    ci = 1'b0;
    is_sub = 1'b0;
    is_arith = 1'b1;
    keep_z = 1'b0;
    upd_c = 1'b1;
    upd_h = 1'b1;
    lk.write_en = 1'b1;
    lk.flag_write = 1'b1;
    r = 8'h00;
    case (lk.op)
      OP_ADD: ci = 1'b0;
      OP_ADD_CARRY: ci = lk.status_old[`FLAG_C];
      OP_SUB, OP_SUBTRACT_IMMEDIATE: is_sub = 1'b1;
      OP_SUB_CARRY, OP_SUBTRACT_IMMEDIATE_BORROW:
      begin
        is_sub = 1'b1;
        ci = lk.status_old[`FLAG_C];
        keep_z = 1'b1;
      end
      OP_CMP, OP_CMP_IMMEDIATE:
      begin
        is_sub = 1'b1;
        lk.write_en = 1'b0;
      end
      OP_CMP_CARRY:
      begin
        is_sub = 1'b1;
        ci = lk.status_old[`FLAG_C];
        keep_z = 1'b1;
        lk.write_en = 1'b0;
      end
      OP_NEG:
      begin
        a = 8'h00;
        b = lk.rd;
        is_sub = 1'b1;
      end
      OP_INC, OP_DEC:
      begin
        b = 8'h01;
        is_sub = (lk.op == OP_DEC);
        upd_c = 1'b0;
        upd_h = 1'b0;
      end
      default:
      begin
        is_arith = 1'b0;
        upd_c = (lk.op == OP_COM);
        upd_h = 1'b0;
        case (lk.op)
          OP_AND: r = lk.rd & lk.operand;
          OP_AND_IMMEDIATE: r = lk.rd & lk.operand;
          OP_OR, OP_OR_IMMEDIATE: r = lk.rd | lk.operand;
          OP_SET_REGISTER_BITS: r = lk.rd | lk.operand;
          OP_CLEAR_REGISTER_BITS: r = lk.rd & ~lk.operand;
          OP_TEST_REGISTER:
          begin
            r = lk.rd & lk.rd;
            lk.write_en = 1'b0;
          end
          OP_EOR: r = lk.rd ^ lk.operand;
          OP_COM: r = ~lk.rd;
          OP_CLR: r = 8'h00;
          OP_SER:
          begin
            r = 8'hff;
            lk.flag_write = 1'b0;
          end
          default:
          begin
            lk.write_en = 1'b0;
            lk.flag_write = 1'b0;
          end
        endcase
      end
    endcase
    sum = is_sub ? ({1'b0, a} - {1'b0, b} - {8'h00, ci}) : ({1'b0, a} + {1'b0, b} + {8'h00, ci});
    if (is_arith)
    begin
      r = sum[7:0];
    end
  end

  // Carry, half carry and overflow follow the borrow convention on subtraction
  always_comb
  begin
    if (!is_arith)
    begin
      c = (lk.op == OP_COM);
      h = 1'b0;
      v = 1'b0;
    end
    else if (is_sub)
    begin
      c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
      h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
      v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    end
    else
    begin
      c = (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]);
      h = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
      v = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
    end
    // Chained subtract keeps zero only if all earlier bytes were zero too
    z = keep_z ? ((r == 8'h00) & lk.status_old[`FLAG_Z]) : (r == 8'h00);
  end

  // Merge fresh flags over the old status; T and I never change here
  always_comb
  begin
    lk.result = r;
    lk.status_new = lk.status_old;
    lk.status_new[`FLAG_Z] = z;
    lk.status_new[`FLAG_N] = r[7];
    lk.status_new[`FLAG_V] = v;
    lk.status_new[`FLAG_S] = r[7] ^ v;
    if (upd_c)
    begin
      lk.status_new[`FLAG_C] = c;
    end
    if (upd_h)
    begin
      lk.status_new[`FLAG_H] = h;
    end
  end
endmodule

// ### logic/alu_link_if.sv
// Carrier between the execute controller and its arithmetic core.
// Assumes both ends sit in the same clock domain; the core is purely combinational.
interface alu_link_if;
  import exec_pkg::*;
  op_type op;
  logic [7:0] rd;
  logic [7:0] operand;
  logic [7:0] status_old;
  logic [7:0] result;
  logic [7:0] status_new;
  logic write_en;
  logic flag_write;
  modport exec (output op, rd, operand, status_old, input result, status_new, write_en,
    flag_write);
  modport core (input op, rd, operand, status_old, output result, status_new, write_en,
    flag_write);
endinterface

// ### logic/exec_map.svh
// Constants of the execute stage: status flag positions, reset values, cycle counts.
// Assumes it is included by bare name by the two design modules.
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH
// Status flag bit positions
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7
// Reset values
`define STATUS_RESET 8'h00
`define PC_RESET 22'h000000
// Cycle counts per instruction class
`define CYC_ONE 3'h1
`define CYC_TWO 3'h2
`define CYC_THREE 3'h3
`define CYC_RETURN 3'h6
// Upper program counter bits cleared by indirect transfers
`define PC_UPPER_ZERO 6'h00
`endif

// ### logic/exec_pkg.sv
// Types of the execute stage: operation codes and controller states.
// Assumes the decoder presents one operation code per accepted request.
package exec_pkg;
  typedef enum logic [5:0] {
    OP_NOP, OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_CARRY, OP_SUBTRACT_IMMEDIATE,
    OP_SUBTRACT_IMMEDIATE_BORROW, OP_WORD_ADD_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE,
    OP_AND, OP_AND_IMMEDIATE, OP_OR, OP_OR_IMMEDIATE, OP_EOR, OP_COM, OP_NEG,
    OP_SET_REGISTER_BITS, OP_CLEAR_REGISTER_BITS, OP_INC, OP_DEC, OP_TEST_REGISTER,
    OP_CLR, OP_SER, OP_CMP, OP_CMP_CARRY, OP_CMP_IMMEDIATE,
    OP_RELATIVE_JUMP, OP_INDIRECT_JUMP, OP_RELATIVE_CALL, OP_INDIRECT_CALL,
    OP_RETURN, OP_INTERRUPT_RETURN, OP_COMPARE_SKIP_EQUAL,
    OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
    OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR, OP_BRANCH_EQUAL, OP_BRANCH_NOT_EQUAL,
    OP_BRANCH_MINUS, OP_BRANCH_PLUS, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
    OP_BRANCH_UNSIGNED_GE, OP_BRANCH_UNSIGNED_LT, OP_BRANCH_CARRY_CLEAR, OP_BRANCH_CARRY_SET,
    OP_BRANCH_HALFCARRY_SET, OP_BRANCH_HALFCARRY_CLEAR, OP_BRANCH_TRANSFER_SET,
    OP_BRANCH_TRANSFER_CLEAR, OP_BRANCH_OVERFLOW_SET, OP_BRANCH_OVERFLOW_CLEAR,
    OP_BRANCH_IRQ_ENABLED, OP_BRANCH_IRQ_DISABLED
  } op_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } state_type;
endpackage

// ### tb/exec_partner.sv
// Partner model: program counter and one-deep return stack of the decoder side.
// Assumes the stage reports each finished operation with done_out.
module exec_partner #(
  parameter logic [21:0] PC_START = 22'h3f0010 // Start address, upper bits set on purpose
) (
  input wire logic mclk_in, // Core clock
  input wire logic reset_in, // Synchronous reset
  input wire logic done_out, // Operation finished
  input wire logic push_out, // Return address push
  input wire logic [21:0] pc_out, // Next program counter
  input wire logic [21:0] push_addr_out, // Return address to keep
  output logic [21:0] pc_in, // Current instruction address
  output logic [21:0] stack_pc_in // Top of return stack
);
  timeunit 1ns;
  timeprecision 1ns;
  // Follow the next address; updated on the falling edge like the bench
  always @(negedge mclk_in)
  begin
    if (reset_in) pc_in <= PC_START;
    else if (done_out) pc_in <= pc_out;
  end
  // One entry only: a nested call would overwrite the outer return address
  always @(negedge mclk_in)
  begin
    if (reset_in) stack_pc_in <= 22'h000000;
    else if (push_out) stack_pc_in <= push_addr_out;
  end
endmodule

// ### tb/tb_alu_branch_execute.sv
// Self-checking bench of the execute stage with the pc and stack partner.
// Assumes inputs change on the falling edge and the stage samples on the rising one.
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; \
  $display("ERROR %0t got %h expected %h", $time, got, exp); end end
module tb_alu_branch_execute;
  timeunit 1ns;
  timeprecision 1ns;
  import exec_pkg::*;
  logic mclk_in = 1'b0, reset_in = 1'b1, op_valid_in = 1'b0, use_imm_in = 1'b0;
  logic next_two_word_in = 1'b0, status_write_in = 1'b0;
  op_type op_code_in = OP_NOP;
  logic [7:0] rd_in = 8'h00, rr_in = 8'h00, imm_in = 8'h00, status_wdata_in = 8'h00;
  logic [11:0] offset_in = 12'h000;
  logic [7:0] io_byte_in = 8'h00;
  logic [2:0] bit_sel_in = 3'h0;
  logic [15:0] z_in = 16'h0000;
  logic [21:0] pc_in, stack_pc_in, pc_out, push_addr_out, exp_pc, ret_pc;
  logic [7:0] result_out, status_out;
  logic [2:0] cycles_out;
  logic result_we_out, done_out, busy_out, push_out, illegal_out;
  int errors = 0, comparisons = 0, cyc, ticks = 0;
  alu_branch_execute alu_branch_execute_inst (.mclk_in(mclk_in), .reset_in(reset_in),
    .op_valid_in(op_valid_in), .op_code_in(op_code_in), .rd_in(rd_in), .rr_in(rr_in),
    .imm_in(imm_in), .use_imm_in(use_imm_in), .io_byte_in(io_byte_in), .bit_sel_in(bit_sel_in),
    .offset_in(offset_in), .pc_in(pc_in), .z_in(z_in), .stack_pc_in(stack_pc_in),
    .next_two_word_in(next_two_word_in), .status_write_in(status_write_in),
    .status_wdata_in(status_wdata_in), .result_out(result_out),
    .result_we_out(result_we_out), .status_out(status_out), .pc_out(pc_out),
    .done_out(done_out), .busy_out(busy_out), .cycles_out(cycles_out),
    .push_out(push_out), .push_addr_out(push_addr_out), .illegal_out(illegal_out));
  exec_partner exec_partner_inst (.mclk_in(mclk_in), .reset_in(reset_in),
    .done_out(done_out), .push_out(push_out), .pc_out(pc_out),
    .push_addr_out(push_addr_out), .pc_in(pc_in), .stack_pc_in(stack_pc_in));
  // 20 MHz core clock
  initial
  begin
    forever #25 mclk_in = ~mclk_in;
  end
  // A hang is cut short well beyond the fewer than sixty cycles the run needs
  always @(posedge mclk_in)
  begin
    ticks++;
    if (ticks == 2000)
    begin
      errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Offer one op after an idle edge, so the valid line never drops and rises in one step;
  // return at the falling edge where done_out stands
  task automatic issue(op_type op, logic [7:0] rd, logic [7:0] rr);
    @(negedge mclk_in);
    op_code_in = op;
    rd_in = rd;
    rr_in = rr;
    op_valid_in = 1'b1;
    @(negedge mclk_in);
    op_valid_in = 1'b0;
    cyc = 1;
    while (done_out !== 1'b1 && cyc < 8)
    begin
      @(negedge mclk_in);
      cyc++;
    end
  endtask
  task automatic load_status(logic [7:0] v);
    status_write_in = 1'b1;
    status_wdata_in = v;
    @(negedge mclk_in);
    status_write_in = 1'b0;
    `CHK(status_out, v)
  endtask
  // AND keeps C and H, then an immediate subtract with a half borrow
  task automatic t_logic();
    load_status(8'h21);
    issue(OP_AND, 8'hf0, 8'h0f);
    exp_pc = exp_pc + 22'h1;
    `CHK(status_out, 8'h23)
    `CHK({result_out, result_we_out, pc_out, cyc[2:0]}, {8'h00, 1'b1, exp_pc, 3'h1})
    use_imm_in = 1'b1;
    imm_in = 8'h01;
    issue(OP_SUBTRACT_IMMEDIATE, 8'h10, 8'hee);
    use_imm_in = 1'b0;
    exp_pc = exp_pc + 22'h1;
    `CHK({result_out, status_out, cycles_out, cyc[2:0]}, {8'h0f, 8'h20, 3'h1, 3'h1})
  endtask
  // Word immediate add is refused: no write, flags kept, next address only
  task automatic t_refuse();
    issue(OP_WORD_ADD_IMMEDIATE, 8'h01, 8'h02);
    exp_pc = exp_pc + 22'h1;
    `CHK({illegal_out, result_we_out, status_out, pc_out}, {2'b10, 8'h20, exp_pc})
  endtask
  // Equal compare skips a two-word instruction, unequal does not
  task automatic t_skip();
    next_two_word_in = 1'b1;
    issue(OP_COMPARE_SKIP_EQUAL, 8'h5a, 8'h5a);
    exp_pc = exp_pc + 22'h3;
    `CHK({pc_out, cycles_out, cyc[2:0]}, {exp_pc, 3'h2, 3'h2})
    issue(OP_COMPARE_SKIP_EQUAL, 8'h5a, 8'h5b);
    exp_pc = exp_pc + 22'h1;
    `CHK({pc_out, cycles_out}, {exp_pc, 3'h1})
    next_two_word_in = 1'b0;
  endtask
  // Signed less-than on N xor V, with a backward offset
  task automatic t_branch();
    offset_in = 12'hff0;
    issue(OP_BRANCH_SIGNED_LT, 8'h00, 8'h00);
    exp_pc = exp_pc + 22'h1;
    `CHK({pc_out, cycles_out}, {exp_pc, 3'h1})
    load_status(8'h04);
    issue(OP_BRANCH_SIGNED_LT, 8'h00, 8'h00);
    exp_pc = exp_pc + {{10{offset_in[11]}}, offset_in} + 22'h1;
    `CHK({pc_out, cycles_out, cyc[2:0]}, {exp_pc, 3'h2, 3'h2})
  endtask
  // Indirect call clears the upper address bits; interrupt return pops it and sets I
  task automatic t_call();
    z_in = 16'h1234;
    ret_pc = exp_pc + 22'h1;
    issue(OP_INDIRECT_CALL, 8'h00, 8'h00);
    `CHK({pc_out, push_out, push_addr_out, cyc[2:0]}, {22'h001234, 1'b1, ret_pc, 3'h3})
    issue(OP_INTERRUPT_RETURN, 8'h00, 8'h00);
    exp_pc = ret_pc;
    `CHK({pc_out, status_out[7], cycles_out, cyc[2:0]}, {exp_pc, 1'b1, 3'h6, 3'h6})
  endtask
  // Bit skips over one-word ops, flag branch on I, lower not taken, jump, test, AND immediate
  task automatic t_more();
    io_byte_in = 8'h08;
    bit_sel_in = 3'h3;
    offset_in = 12'h005;
    issue(OP_SKIP_IO_BIT_SET, 8'h00, 8'h00);
    exp_pc = exp_pc + 22'h2;
    `CHK({pc_out, cycles_out, cyc[2:0]}, {exp_pc, 3'h2, 3'h2})
    issue(OP_SKIP_REG_BIT_CLEAR, 8'h00, 8'hf7);
    exp_pc = exp_pc + 22'h2;
    `CHK({pc_out, cycles_out}, {exp_pc, 3'h2})
    issue(OP_COMPARE_SKIP_EQUAL, 8'h33, 8'h33);
    exp_pc = exp_pc + 22'h2;
    `CHK({pc_out, cycles_out}, {exp_pc, 3'h2})
    bit_sel_in = 3'h7;
    issue(OP_BRANCH_FLAG_SET, 8'h00, 8'h00);
    exp_pc = exp_pc + 22'h6;
    `CHK({pc_out, cycles_out, cyc[2:0]}, {exp_pc, 3'h2, 3'h2})
    issue(OP_BRANCH_UNSIGNED_LT, 8'h00, 8'h00);
    exp_pc = exp_pc + 22'h1;
    `CHK({pc_out, cycles_out}, {exp_pc, 3'h1})
    issue(OP_INDIRECT_JUMP, 8'h00, 8'h00);
    `CHK({pc_out, cycles_out, cyc[2:0]}, {22'h001234, 3'h2, 3'h2})
    issue(OP_TEST_REGISTER, 8'h80, 8'h00);
    `CHK({status_out, result_we_out, pc_out}, {8'h94, 1'b0, 22'h001235})
    load_status(8'ha1);
    use_imm_in = 1'b1;
    imm_in = 8'h0f;
    issue(OP_AND_IMMEDIATE, 8'h3c, 8'h00);
    use_imm_in = 1'b0;
    `CHK({result_out, result_we_out, status_out}, {8'h0c, 1'b1, 8'ha1})
  endtask
  // Main sequence
  initial
  begin
    exp_pc = 22'h3f0010;
    repeat (2) @(negedge mclk_in);
    reset_in = 1'b0;
    `CHK({status_out, done_out, busy_out}, {8'h00, 2'b00})
    t_logic();
    t_refuse();
    t_skip();
    t_branch();
    t_call();
    t_more();
    test_done();
  end
endmodule
